// File: hdl/smc_read_pkg.sv
// shared types and constants for the static memory read interface
// Functional notes
// - 26 address lines, 64-Mbyte window per select
// - small memories alias across the whole window
// - address bits used depend on bus width
// - per select width of 8, 16 or 32
// - wide buses use write strobes or lane selects
// - write strobe mode: one strobe per lane
// - no booting in write strobe mode
// - lane select mode: one select per lane
// - shared pins follow width and access type
// - unused pins per width and mode stay idle
// - lane selects switch with the address
// - write strobes behave like the write enable
// - read starts by driving the address
// - read strobe setup, pulse, then hold
// - chip select has own setup, pulse, hold
// - read timings per select in clock cycles
// - hold is cycle minus setup minus pulse
// - zero setup and hold keeps strobes low
// - read mode bit picks the sampling strobe
// - mode 1 samples at read strobe rise
// - mode 0 samples at chip select rise
package smc_read_pkg;
  localparam int NUM_CS = 8;
  localparam int CS_W = 3;
  localparam int ADDR_W = 26;
  localparam int DATA_W = 32;
  localparam int LANES = 4;
  localparam int TIME_W = 9;
  localparam int SYNC_STAGES = 2;
  localparam logic [TIME_W-1:0] ONE_CYC = 9'h001;
  localparam logic [LANES-1:0] PINS_IDLE = 4'hf;
  localparam logic [NUM_CS-1:0] CS_IDLE = 8'hff;
  localparam logic [LANES-1:0] LANES_NONE = 4'h0;

  typedef enum logic [1:0] {
    WIDTH_8 = 2'b00,
    WIDTH_16 = 2'b01,
    WIDTH_32 = 2'b10
  } bus_width_field_t;

  typedef enum logic {
    ACC_LANE_SELECT = 1'b0,
    ACC_WRITE_STROBE = 1'b1
  } byte_access_type_t;

  typedef enum logic {
    SAMPLE_ON_CS = 1'b0,
    SAMPLE_ON_RD = 1'b1
  } read_mode_t;

  // per chip select mode and read timing, counts in clock cycles
  typedef struct packed {
    bus_width_field_t bus_width_field;
    byte_access_type_t byte_access_type;
    read_mode_t read_mode;
    logic [TIME_W-1:0] read_strobe_setup;
    logic [TIME_W-1:0] read_strobe_pulse;
    logic [TIME_W-1:0] cs_read_setup;
    logic [TIME_W-1:0] cs_read_pulse;
    logic [TIME_W-1:0] read_cycle_length;
  } cs_cfg_t;

  typedef struct packed {
    logic [CS_W-1:0] cs;
    logic [ADDR_W-1:0] addr;
    logic [LANES-1:0] byte_en;
  } rd_req_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ACCESS = 2'b01,
    ST_GAP = 2'b10
  } rd_state_t;
endpackage

// File: hdl/static_memory_read_interface.sv
// static memory read waveform generator with shared pin multiplexing
`timescale 1ns/1ps
module static_memory_read_interface
  import smc_read_pkg::*;
(
  input wire logic clock_in,
  input wire logic reset_n_in,
  input wire cs_cfg_t [NUM_CS-1:0] cs_cfg_in,
  input wire logic req_valid_in,
  input wire rd_req_t req_in,
  output logic req_ready_out,
  output logic rd_valid_out,
  output logic [DATA_W-1:0] rd_data_out,
  output logic boot_cfg_bad_out,
  output logic [ADDR_W-1:2] ext_addr_out,
  output logic [NUM_CS-1:0] chip_select_line_n_out,
  output logic read_strobe_n_out,
  output logic a0_lane0_select_out,
  output logic write_enable_lane0_write_strobe_out,
  output logic lane1_select_write_strobe_out,
  output logic a1_lane2_select_write_strobe_out,
  output logic lane3_select_write_strobe_out,
  input wire logic [DATA_W-1:0] data_pin_in,
  output logic [DATA_W-1:0] data_pin_out,
  output logic data_pin_oe_out
);

  rd_state_t state_q;
  rd_req_t cur_q;
  cs_cfg_t cfg_q;
  cs_cfg_t cfg_new;
  logic [TIME_W-1:0] cnt_q;
  logic [TIME_W-1:0] cnt_d;
  logic [NUM_CS-1:0] cs_n_q;
  logic rd_n_q;
  logic [LANES-1:0] pins_q;
  logic [ADDR_W-1:2] addr_q;
  logic [DATA_W-1:0] d_s1_q;
  logic [DATA_W-1:0] d_s2_q;
  logic cap_p1_q;
  logic cap_p2_q;
  logic rd_valid_q;
  logic [DATA_W-1:0] rd_data_q;
  logic boot_bad_q;
  logic last_cyc;
  logic take;
  logic cap_end;
  logic [TIME_W:0] end_idx;
  logic in_access_d;
  rd_req_t req_d;
  cs_cfg_t cfg_d;

  // true while cycle index sits inside setup .. setup+pulse-1
  function automatic logic in_pulse(input logic [TIME_W-1:0] idx,
                                    input logic [TIME_W-1:0] setup,
                                    input logic [TIME_W-1:0] pulse);
    logic [TIME_W:0] lim;
    lim = {1'b0, setup} + {1'b0, pulse};
    return ({1'b0, idx} >= {1'b0, setup}) && ({1'b0, idx} < lim);
  endfunction

  // lanes that the access really touches, per bus width
  function automatic logic [LANES-1:0] lane_mask(input cs_cfg_t c,
                                                 input rd_req_t r);
    logic [LANES-1:0] m;
    m = LANES_NONE;
    case (c.bus_width_field)
      WIDTH_16: m = {2'b00, r.addr[1] ? r.byte_en[3:2] : r.byte_en[1:0]};
      WIDTH_32: m = r.byte_en;
      default: m = LANES_NONE;
    endcase
    return m;
  endfunction

  // shared pins {pin3, pin2, pin1, pin0}; write strobes idle on reads
  function automatic logic [LANES-1:0] pin_map(input cs_cfg_t c,
                                               input rd_req_t r,
                                               input logic [LANES-1:0] m);
    logic [LANES-1:0] p;
    p = PINS_IDLE;
    case (c.bus_width_field)
      WIDTH_8:
      begin
        p[0] = r.addr[0];
        p[2] = r.addr[1];
      end
      WIDTH_16:
      begin
        p[2] = r.addr[1];
        if (c.byte_access_type == ACC_LANE_SELECT)
        begin
          p[1:0] = ~m[1:0];
        end
      end
      WIDTH_32:
      begin
        if (c.byte_access_type == ACC_LANE_SELECT)
        begin
          p = ~m;
        end
      end
      default: p = PINS_IDLE;
    endcase
    return p;
  endfunction

  always_comb
  begin
    cfg_new = cs_cfg_in[req_in.cs];
    end_idx = (cfg_q.read_mode == SAMPLE_ON_RD) ?
      {1'b0, cfg_q.read_strobe_setup} + {1'b0, cfg_q.read_strobe_pulse} :
      {1'b0, cfg_q.cs_read_setup} + {1'b0, cfg_q.cs_read_pulse};
    cap_end = (state_q == ST_ACCESS) &&
      ({1'b0, cnt_q} + {1'b0, ONE_CYC} == end_idx);
    last_cyc = (state_q == ST_ACCESS) &&
      (cnt_q + ONE_CYC >= cfg_q.read_cycle_length);
    take = req_valid_in && ((state_q == ST_IDLE) ||
      (last_cyc && req_in.cs == cur_q.cs));
  end

  assign req_ready_out = (state_q == ST_IDLE) ||
    (last_cyc && req_in.cs == cur_q.cs);

  always_comb
  begin
    cnt_d = cnt_q + ONE_CYC;
    req_d = cur_q;
    cfg_d = cfg_q;
    in_access_d = (state_q == ST_ACCESS) && !last_cyc;
    if (take)
    begin
      cnt_d = '0;
      req_d = req_in;
      cfg_d = cfg_new;
      in_access_d = 1'b1;
    end
  end

  // sequencing: idle, access cycles, one idle gap after each run
  always_ff @(posedge clock_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      state_q <= ST_IDLE;
      cnt_q <= '0;
      cur_q <= '0;
      cfg_q <= '0;
    end
    else
    begin
      cnt_q <= in_access_d ? cnt_d : '0;
      cur_q <= req_d;
      cfg_q <= cfg_d;
      case (state_q)
        ST_IDLE: state_q <= take ? ST_ACCESS : ST_IDLE;
        ST_ACCESS:
        begin
          if (last_cyc && !take)
          begin
            state_q <= ST_GAP;
          end
        end
        ST_GAP: state_q <= ST_IDLE;
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // registered pin levels for the cycle index that comes next
  always_ff @(posedge clock_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      cs_n_q <= CS_IDLE;
      rd_n_q <= 1'b1;
      pins_q <= PINS_IDLE;
      addr_q <= '0;
    end
    else
    begin
      cs_n_q <= CS_IDLE;
      rd_n_q <= 1'b1;
      pins_q <= PINS_IDLE;
      if (in_access_d)
      begin
        addr_q <= req_d.addr[ADDR_W-1:2];
        pins_q <= pin_map(cfg_d, req_d, lane_mask(cfg_d, req_d));
        rd_n_q <= !in_pulse(cnt_d, cfg_d.read_strobe_setup,
                            cfg_d.read_strobe_pulse);
        cs_n_q[req_d.cs] <= !in_pulse(cnt_d, cfg_d.cs_read_setup,
                                      cfg_d.cs_read_pulse);
      end
    end
  end

  // data pins pass two stages before capture
  always_ff @(posedge clock_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      d_s1_q <= '0;
      d_s2_q <= '0;
    end
    else
    begin
      d_s1_q <= data_pin_in;
      d_s2_q <= d_s1_q;
    end
  end

  // capture lags the sampling edge by the synchroniser depth
  always_ff @(posedge clock_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      cap_p1_q <= 1'b0;
      cap_p2_q <= 1'b0;
      rd_valid_q <= 1'b0;
      rd_data_q <= '0;
    end
    else
    begin
      cap_p1_q <= cap_end;
      cap_p2_q <= cap_p1_q;
      rd_valid_q <= cap_p2_q;
      if (cap_p2_q)
      begin
        rd_data_q <= d_s2_q;
      end
    end
  end

  // boot select must not use write strobe style
  always_ff @(posedge clock_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      boot_bad_q <= 1'b0;
    end
    else
    begin
      boot_bad_q <= (cs_cfg_in[0].byte_access_type ==
                     ACC_WRITE_STROBE);
    end
  end

  assign rd_valid_out = rd_valid_q;
  assign boot_cfg_bad_out = boot_bad_q;
  assign rd_data_out = rd_data_q;
  assign ext_addr_out = addr_q;
  assign chip_select_line_n_out = cs_n_q;
  assign read_strobe_n_out = rd_n_q;
  assign a0_lane0_select_out = pins_q[0];
  assign write_enable_lane0_write_strobe_out = 1'b1;
  assign lane1_select_write_strobe_out = pins_q[1];
  assign a1_lane2_select_write_strobe_out = pins_q[2];
  assign lane3_select_write_strobe_out = pins_q[3];
  assign data_pin_out = '0;
  assign data_pin_oe_out = 1'b0;

  a_idle_inactive: assert property (@(posedge clock_in)
    disable iff (!reset_n_in)
    (state_q != ST_ACCESS) |-> (cs_n_q == CS_IDLE && rd_n_q &&
      !data_pin_oe_out))
    else $error("strobes active outside an access");

  a_rd_window: assert property (@(posedge clock_in)
    disable iff (!reset_n_in)
    (state_q == ST_ACCESS && cnt_q == cfg_q.read_strobe_setup)
      |-> !rd_n_q)
    else $error("read strobe not low after setup");

  a_rd_hold_high: assert property (@(posedge clock_in)
    disable iff (!reset_n_in)
    (state_q == ST_ACCESS && {1'b0, cnt_q} >=
      {1'b0, cfg_q.read_strobe_setup} + {1'b0, cfg_q.read_strobe_pulse})
      |-> rd_n_q)
    else $error("read strobe low during hold");

  a_cs_window: assert property (@(posedge clock_in)
    disable iff (!reset_n_in)
    (state_q == ST_ACCESS && cnt_q < cfg_q.cs_read_setup)
      |-> cs_n_q == CS_IDLE)
    else $error("chip select low during its setup");

  a_cs_one_hot: assert property (@(posedge clock_in)
    disable iff (!reset_n_in)
    $onehot0(~cs_n_q) && (cs_n_q == CS_IDLE ||
      !cs_n_q[cur_q.cs]))
    else $error("wrong chip select asserted");

  a_capture_lat: assert property (@(posedge clock_in)
    disable iff (!reset_n_in)
    cap_end |-> ##3 (rd_valid_out &&
      rd_data_out == $past(data_pin_in, 3)))
    else $error("read data not returned three cycles after sample");

  a_rd_mode_edge: assert property (@(posedge clock_in)
    disable iff (!reset_n_in)
    (cap_end && cfg_q.read_mode == SAMPLE_ON_RD && !take)
      |-> !rd_n_q ##1 rd_n_q)
    else $error("read strobe did not rise at sampling edge");

  a_cs_mode_edge: assert property (@(posedge clock_in)
    disable iff (!reset_n_in)
    (cap_end && cfg_q.read_mode == SAMPLE_ON_CS && !take)
      |-> !cs_n_q[cur_q.cs] ##1 cs_n_q == CS_IDLE)
    else $error("chip select did not rise at sampling edge");

  a_lane_mask: assert property (@(posedge clock_in)
    disable iff (!reset_n_in)
    (state_q == ST_ACCESS && cfg_q.bus_width_field == WIDTH_32 &&
      cfg_q.byte_access_type == ACC_LANE_SELECT)
      |-> pins_q == ~cur_q.byte_en)
    else $error("lane selects differ from addressed bytes");

  a_gap_after_run: assert property (@(posedge clock_in)
    disable iff (!reset_n_in)
    (last_cyc && !take) |=> state_q == ST_GAP ##1 state_q == ST_IDLE)
    else $error("no idle gap after an access run");

  a_cs_pulse_low: assert property (@(posedge clock_in)
    disable iff (!reset_n_in)
    (state_q == ST_ACCESS && cnt_q == cfg_q.cs_read_setup)
      |-> !cs_n_q[cur_q.cs])
    else $error("chip select not low after its setup");

  a_addr_held: assert property (@(posedge clock_in)
    disable iff (!reset_n_in)
    (state_q == ST_ACCESS)
      |-> ext_addr_out == cur_q.addr[ADDR_W-1:2])
    else $error("address pins differ from the request");

  a_narrow_mux: assert property (@(posedge clock_in)
    disable iff (!reset_n_in)
    (state_q == ST_ACCESS && cfg_q.bus_width_field == WIDTH_8)
      |-> (a0_lane0_select_out == cur_q.addr[0] &&
      a1_lane2_select_write_strobe_out == cur_q.addr[1]))
    else $error("address bits missing on shared pins");

  a_back_to_back: assert property (@(posedge clock_in)
    disable iff (!reset_n_in)
    (last_cyc && take) |=> (state_q == ST_ACCESS && cnt_q == '0))
    else $error("back to back read did not restart at once");

endmodule // static_memory_read_interface

// File: verif/async_mem_model.sv
// behavioural asynchronous memory on the far side of the read pins
`timescale 1ns/1ps
module async_mem_model
  import smc_read_pkg::*;
(
  input wire logic [ADDR_W-1:2] addr_in,
  input wire logic sel_n_in,
  input wire logic rd_n_in,
  output logic [DATA_W-1:0] data_out
);
  logic [DATA_W-1:0] last_word;

  initial last_word = 32'h0;

  // only low word address decoded, so contents repeat
  always @(addr_in, sel_n_in, rd_n_in)
  begin
    if (!sel_n_in && !rd_n_in)
    begin
      last_word = {16'hc3a5, 12'h0, addr_in[5:2]};
      data_out = last_word;
    end
    else
      data_out = ~last_word;
  end
endmodule // async_mem_model

// File: verif/tb_static_memory_read_interface.sv
// self-checking bench for the static memory read interface
`timescale 1ns/1ps
module tb_static_memory_read_interface;
  import smc_read_pkg::*;
  typedef struct packed {
    cs_cfg_t cfg;
    logic [CS_W-1:0] cs;
    logic [ADDR_W-1:0] addr;
    logic [LANES-1:0] be;
    logic [3:0] mux;
    logic [DATA_W-1:0] data;
  } row_t;
  localparam row_t ROWS [5] = '{
    '{'{WIDTH_32, ACC_LANE_SELECT, SAMPLE_ON_RD, 9'h1, 9'h2, 9'h0, 9'h4,
      9'h4}, 3'h1, 26'h10, 4'h6, 4'h9, 32'hc3a50004},
    '{'{WIDTH_16, ACC_LANE_SELECT, SAMPLE_ON_CS, 9'h0, 9'h4, 9'h1, 9'h2,
      9'h5}, 3'h3, 26'h3ffff06, 4'hc, 4'h3, 32'hc3a50001},
    '{'{WIDTH_8, ACC_LANE_SELECT, SAMPLE_ON_RD, 9'h0, 9'h2, 9'h0, 9'h2,
      9'h2}, 3'h1, 26'h2, 4'h4, 4'h7, 32'hc3a50000},
    '{'{WIDTH_32, ACC_WRITE_STROBE, SAMPLE_ON_RD, 9'h1, 9'h2, 9'h0, 9'h6,
      9'h6}, 3'h3, 26'h20, 4'hf, 4'hf, 32'hc3a50008},
    '{'{WIDTH_32, ACC_LANE_SELECT, SAMPLE_ON_RD, 9'h1, 9'h2, 9'h0, 9'h1,
      9'h3}, 3'h2, 26'h30, 4'h1, 4'h7, 32'h3c5afff7}};
  logic clock_in, reset_n_in, req_valid_in, req_ready_out, rd_valid_out;
  logic boot_bad, oe, rd_n, p0, pwe, p1, p2, p3;
  cs_cfg_t [NUM_CS-1:0] cs_cfg;
  rd_req_t req;
  logic [DATA_W-1:0] rd_data, pin_d, dout;
  logic [ADDR_W-1:2] ext_addr;
  logic [NUM_CS-1:0] cs_n;
  int err_count = 0;
  int check_count = 0;

  static_memory_read_interface dut (.clock_in(clock_in),
    .reset_n_in(reset_n_in), .cs_cfg_in(cs_cfg), .req_valid_in(req_valid_in),
    .req_in(req), .req_ready_out(req_ready_out), .rd_valid_out(rd_valid_out),
    .rd_data_out(rd_data), .boot_cfg_bad_out(boot_bad),
    .ext_addr_out(ext_addr), .chip_select_line_n_out(cs_n),
    .read_strobe_n_out(rd_n), .a0_lane0_select_out(p0),
    .write_enable_lane0_write_strobe_out(pwe),
    .lane1_select_write_strobe_out(p1),
    .a1_lane2_select_write_strobe_out(p2),
    .lane3_select_write_strobe_out(p3), .data_pin_in(pin_d),
    .data_pin_out(dout), .data_pin_oe_out(oe));

  async_mem_model mem (.addr_in(ext_addr), .sel_n_in(&cs_n), .rd_n_in(rd_n),
    .data_out(pin_d));

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      err_count++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict;
    $display("checks=%0d errors=%0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic tick;
    @(posedge clock_in);
    #1;
  endtask

  task automatic wait_ready;
    for (int i = 0; i < 20 && req_ready_out !== 1'b1; i++)
      tick();
  endtask

  // one read, pins checked each cycle of the access
  task automatic do_read(input row_t r);
    int rs, re, cb, ce, cyc;
    logic got;
    logic [NUM_CS-1:0] e_cs;
    logic e_rd;
    rs = r.cfg.read_strobe_setup;
    re = rs + r.cfg.read_strobe_pulse;
    cb = r.cfg.cs_read_setup;
    ce = cb + r.cfg.cs_read_pulse;
    cyc = r.cfg.read_cycle_length;
    got = 1'b0;
    cs_cfg[r.cs] = r.cfg;
    req = '{r.cs, r.addr, r.be};
    req_valid_in = 1'b1;
    wait_ready();
    tick();
    req_valid_in = 1'b0;
    for (int i = 0; i < cyc + 10; i++)
    begin
      e_cs = (i >= cb && i < ce) ? ~(8'h01 << r.cs) : CS_IDLE;
      e_rd = !(i >= rs && i < re);
      if (i < cyc)
        check({cs_n, rd_n, p0, p1, p2, p3, pwe, ext_addr, oe},
          {e_cs, e_rd, r.mux, 1'b1, r.addr[25:2], 1'b0});
      else if (i == cyc)
        check({cs_n, rd_n, oe}, {CS_IDLE, 1'b1, 1'b0});
      if (rd_valid_out === 1'b1)
      begin
        got = 1'b1;
        check(rd_data, r.data);
      end
      tick();
    end
    check(got, 1'b1);
  endtask

  initial
  begin
    clock_in = 1'b0;
    forever #2 clock_in = ~clock_in;
  end

  initial
  begin
    #20000;
    err_count++;
    print_verdict();
  end

  initial
  begin
    reset_n_in = 1'b0;
    req_valid_in = 1'b0;
    req = '0;
    for (int k = 0; k < NUM_CS; k++)
      cs_cfg[k] = '{WIDTH_16, ACC_LANE_SELECT, SAMPLE_ON_RD, 9'h1, 9'h1,
        9'h1, 9'h1, 9'h2};
    repeat (2) @(posedge clock_in);
    #1;
    check({cs_n, rd_n, rd_valid_out, req_ready_out},
      {CS_IDLE, 1'b1, 1'b0, 1'b1});
    reset_n_in = 1'b1;
    tick();
    foreach (ROWS[k])
      do_read(ROWS[k]);
    // back to back reads, zero setup and hold
    cs_cfg[2] = '{WIDTH_32, ACC_LANE_SELECT, SAMPLE_ON_RD, 9'h0, 9'h2,
      9'h0, 9'h2, 9'h2};
    req = '{3'h2, 26'h4, 4'hf};
    req_valid_in = 1'b1;
    wait_ready();
    tick();
    req.addr = 26'h8;
    for (int k = 0; k < 4; k++)
    begin
      check({cs_n, rd_n}, {~8'h04, 1'b0});
      if (k == 1)
        check(req_ready_out, 1'b1);
      if (k == 2)
        check(ext_addr, 24'h2);
      tick();
      if (k == 1)
        req_valid_in = 1'b0;
    end
    repeat (10) tick();
    cs_cfg[0].byte_access_type = ACC_WRITE_STROBE;
    repeat (2) tick();
    check(boot_bad, 1'b1);
    cs_cfg[0].byte_access_type = ACC_LANE_SELECT;
    repeat (2) tick();
    check(boot_bad, 1'b0);
    // reset pulled in the middle of an access
    cs_cfg[1] = ROWS[0].cfg;
    req = '{3'h1, 26'h10, 4'hf};
    req_valid_in = 1'b1;
    tick();
    req_valid_in = 1'b0;
    tick();
    check({cs_n, rd_n}, {~8'h02, 1'b0});
    reset_n_in = 1'b0;
    #1;
    check({cs_n, rd_n, p0, p1, p2, p3, rd_valid_out, oe, dout},
      {CS_IDLE, 1'b1, PINS_IDLE, 1'b0, 1'b0, 32'h0});
    tick();
    reset_n_in = 1'b1;
    tick();
    check({cs_n, rd_n, req_ready_out}, {CS_IDLE, 1'b1, 1'b1});
    do_read(ROWS[0]);
    print_verdict();
  end
endmodule // tb_static_memory_read_interface
